/* design/tucr_pkg.sv */
/*
  Constants for the trace unit control register bank: register offsets,
  field positions, buffer space thresholds and widths.
  Assumes a 32-bit APB register bus with byte addresses.
*/
package tucr_pkg;

  // Register byte offsets
  localparam logic [11:0] OFS_STALL_CTRL   = 12'h02C;
  localparam logic [11:0] OFS_TS_CTRL      = 12'h030;
  localparam logic [11:0] OFS_SYNC_PERIOD  = 12'h034;
  localparam logic [11:0] OFS_CC_THRESHOLD = 12'h038;
  localparam logic [11:0] OFS_BB_SCOPE     = 12'h03C;
  localparam logic [11:0] OFS_STATUS       = 12'h044;

  // Writable bit masks; all other bits read as zero
  localparam logic [31:0] MASK_STALL_CTRL   = 32'h00001F0C;
  localparam logic [31:0] MASK_TS_CTRL      = 32'h0000008F;
  localparam logic [31:0] MASK_SYNC_PERIOD  = 32'h0000001F;
  localparam logic [31:0] MASK_CC_THRESHOLD = 32'h00000FFF;
  localparam logic [31:0] MASK_BB_SCOPE     = 32'h0000010F;
  localparam logic [31:0] RESET_VALUE       = 32'h00000000;

  // Stall control fields
  localparam int DROP_SEL_HI   = 12;
  localparam int DROP_SEL_LO   = 11;
  localparam int INSTR_FAV_BIT = 10;
  localparam int DATA_HOLD_BIT = 9;
  localparam int INSTR_HOLD_BIT = 8;
  localparam int LEVEL_HI      = 3;
  localparam int LEVEL_LO      = 2;

  // Drop selection codes
  localparam logic [1:0] DROP_NONE  = 2'h0;
  localparam logic [1:0] DROP_LOAD  = 2'h1;
  localparam logic [1:0] DROP_STORE = 2'h2;
  localparam logic [1:0] DROP_BOTH  = 2'h3;

  // Timestamp control fields
  localparam int TS_KIND_BIT = 7;
  localparam int TS_SEL_HI   = 3;

  // Period field and byte counter
  localparam int          PERIOD_HI    = 4;
  localparam logic [4:0]  PERIOD_MAX   = 5'h14;
  localparam int          SYNC_CNT_W   = 21;
  localparam int          BYTES_W      = 4;

  // Cycle count threshold and branch scope fields
  localparam int CC_HI       = 11;
  localparam int BB_MODE_BIT = 8;
  localparam int RANGE_HI    = 3;
  localparam int NUM_RANGES  = 4;

  // Free-space thresholds in buffer bytes for each stall level
  localparam int          SPACE_W      = 8;
  localparam logic [7:0]  SPACE_LEVEL0 = 8'h00;
  localparam logic [7:0]  SPACE_LEVEL1 = 8'h10;
  localparam logic [7:0]  SPACE_LEVEL2 = 8'h20;
  localparam logic [7:0]  SPACE_LEVEL3 = 8'h40;

  // Status register bits
  localparam int ST_CORE_STALL = 0;
  localparam int ST_DROP_LOAD  = 1;
  localparam int ST_DROP_STORE = 2;
  localparam int ST_INSTR_FAV  = 3;
  localparam int ST_BB_ACTIVE  = 4;
  localparam int ST_DATA_LOW   = 5;
  localparam int ST_INSTR_LOW  = 6;

endpackage

/* design/tucr_resource_select.sv */
/*
  Picks one trace resource or one combined resource pair by index.
  Assumes resource and pair inputs are synchronous levels.
*/
module tucr_resource_select (
  // Selection
  input  wire logic        kind,
  input  wire logic [3:0]  index,
  // Resources
  input  wire logic [15:0] single_res,
  input  wire logic [7:0]  pair_res,
  // Result
  output logic             hit
);

  always_comb begin
    if (kind) begin
      hit = pair_res[index[2:0]];
    end else begin
      hit = single_res[index];
    end
  end

endmodule // tucr_resource_select

/* design/tucr_sync_counter.sv */
/*
  Counts trace bytes of both streams and requests synchronization each
  time two to the power of the period field bytes have gone by.
  Assumes byte counts are sampled on every clock edge.
*/
module tucr_sync_counter (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  // Period
  input  wire logic [4:0]                  period,
  // Bytes generated this cycle
  input  wire logic [tucr_pkg::BYTES_W-1:0] instr_bytes,
  input  wire logic [tucr_pkg::BYTES_W-1:0] data_bytes,
  // Request
  output logic                             sync_req
);

  localparam int W = tucr_pkg::SYNC_CNT_W;

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;
  logic [W-1:0] sum;
  logic [W-1:0] span;
  logic [4:0]   exp_eff;
  logic         req_next;

  always_comb begin
    // Out-of-range periods are clamped to the largest legal period
    exp_eff = (period > tucr_pkg::PERIOD_MAX) ? tucr_pkg::PERIOD_MAX
                                              : period;
    span = W'(1) << exp_eff;
    sum  = count_reg + W'(instr_bytes) + W'(data_bytes);
    if (period == 5'h00) begin
      count_next = '0;
      req_next   = 1'b0;
    end else if (sum >= span) begin
      count_next = sum - span;
      req_next   = 1'b1;
    end else begin
      count_next = sum;
      req_next   = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync_req <= 1'b0;
    end else begin
      sync_req <= req_next;
    end
  end

endmodule // tucr_sync_counter

/* design/tucr_top.sv */
/*
  Trace unit control register bank: stall and drop policy, timestamp
  resource choice, synchronization period, cycle count threshold and
  branch broadcast scope, programmed over APB.
  Assumes APB master on REF_CLK, synchronous inputs from the trace buffer
  and the core, and RSTN synchronous active low.

// Summary of operation
// - Below threshold, drop loads, stores or both per two-bit select.
// - Favour bit set and instruction space low: favour instructions.
// - Data hold bit stalls core while data space is below threshold.
// - Instruction hold bit stalls core while instruction space is low.
// - Two-bit level gives four thresholds; zero never stalls.
// - Timestamps go to instruction stream, and data stream if data traced.
// - Kind bit selects single resource or combined pair.
// - Index picks resource 0-15, or pair 0-7 from low three bits.
// - Request sync every two to the N trace bytes, both streams.
// - Period zero stops periodic sync requests only.
// - Twelve-bit cycle count threshold, readable and writable.
// - Exclude mode: no broadcast in chosen ranges; none chosen means all.
// - Include mode broadcasts only inside chosen ranges.
// - One mask bit per address range comparator.
// - Cycle count threshold applies only with cycle count enable.
// - Branch broadcast scoping applies only with broadcast enable.
*/
module tucr_top (
  // Clock and reset
  input  wire logic                         REF_CLK,
  input  wire logic                         RSTN,

  // APB slave
  input  wire logic                         PSEL,
  input  wire logic                         PENABLE,
  input  wire logic                         PWRITE,
  input  wire logic [11:0]                  PADDR,
  input  wire logic [31:0]                  PWDATA,
  output logic      [31:0]                  PRDATA,
  output logic                              PREADY,
  output logic                              PSLVERR,

  // Trace buffer free space
  input  wire logic [tucr_pkg::SPACE_W-1:0] INSTR_SPACE,
  input  wire logic [tucr_pkg::SPACE_W-1:0] DATA_SPACE,

  // Stall and drop policy
  output logic                              CORE_STALL,
  output logic                              DROP_LOADS,
  output logic                              DROP_STORES,
  output logic                              INSTR_FAVOUR,

  // Timestamp resources
  input  wire logic [15:0]                  RESOURCE,
  input  wire logic [7:0]                   RESOURCE_PAIR,
  input  wire logic                         DATA_TRACE_ON,
  output logic                              TS_INSTR,
  output logic                              TS_DATA,

  // Trace byte counts and sync
  input  wire logic [tucr_pkg::BYTES_W-1:0] INSTR_BYTES,
  input  wire logic [tucr_pkg::BYTES_W-1:0] DATA_BYTES,
  output logic                              SYNC_REQUEST,

  // Cycle counting
  input  wire logic                         CYCLE_COUNT_ENABLE,
  output logic      [11:0]                  CC_THRESHOLD,
  output logic                              CC_ACTIVE,

  // Branch broadcast
  input  wire logic                         BRANCH_BROADCAST_ENABLE,
  input  wire logic [3:0]                   RANGE_HIT,
  output logic                              BB_ACTIVE
);

  // Register storage
  logic [31:0] trace_stall_control_reg;
  logic [31:0] timestamp_event_control_reg;
  logic [31:0] sync_period_reg;
  logic [31:0] cycle_count_threshold_reg;
  logic [31:0] branch_broadcast_scope_reg;

  // Address decode shared by write and read paths
  typedef enum logic [2:0] {
    TUCR_SEL_NONE  = 3'b000,
    TUCR_SEL_STALL = 3'b001,
    TUCR_SEL_TS    = 3'b010,
    TUCR_SEL_SYNC  = 3'b011,
    TUCR_SEL_CC    = 3'b100,
    TUCR_SEL_BB    = 3'b101,
    TUCR_SEL_STAT  = 3'b110
  } tucr_sel_type;

  function automatic tucr_sel_type decode(input logic [11:0] addr);
    unique case (addr)
      tucr_pkg::OFS_STALL_CTRL:   decode = TUCR_SEL_STALL;
      tucr_pkg::OFS_TS_CTRL:      decode = TUCR_SEL_TS;
      tucr_pkg::OFS_SYNC_PERIOD:  decode = TUCR_SEL_SYNC;
      tucr_pkg::OFS_CC_THRESHOLD: decode = TUCR_SEL_CC;
      tucr_pkg::OFS_BB_SCOPE:     decode = TUCR_SEL_BB;
      tucr_pkg::OFS_STATUS:       decode = TUCR_SEL_STAT;
      default:                    decode = TUCR_SEL_NONE;
    endcase
  endfunction

  function automatic logic [7:0] level_space(input logic [1:0] lvl);
    unique case (lvl)
      2'h0: level_space = tucr_pkg::SPACE_LEVEL0;
      2'h1: level_space = tucr_pkg::SPACE_LEVEL1;
      2'h2: level_space = tucr_pkg::SPACE_LEVEL2;
      2'h3: level_space = tucr_pkg::SPACE_LEVEL3;
    endcase
  endfunction

  tucr_sel_type sel;
  logic         wr_en;
  logic         access;
  logic [31:0]  status_word;

  assign sel    = decode(PADDR);
  assign access = PSEL && PENABLE;
  assign wr_en  = access && PWRITE;

  // Zero wait states
  assign PREADY = 1'b1;

  // Unmapped addresses and writes to status answer with an error
  assign PSLVERR = access && ((sel == TUCR_SEL_NONE) ||
                              (PWRITE && (sel == TUCR_SEL_STAT)));

  // Register writes, masked so reserved bits stay zero
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      trace_stall_control_reg <= tucr_pkg::RESET_VALUE;
    end else if (wr_en && sel == TUCR_SEL_STALL) begin
      trace_stall_control_reg <= PWDATA & tucr_pkg::MASK_STALL_CTRL;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      timestamp_event_control_reg <= tucr_pkg::RESET_VALUE;
    end else if (wr_en && sel == TUCR_SEL_TS) begin
      timestamp_event_control_reg <= PWDATA & tucr_pkg::MASK_TS_CTRL;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      sync_period_reg <= tucr_pkg::RESET_VALUE;
    end else if (wr_en && sel == TUCR_SEL_SYNC) begin
      sync_period_reg <= PWDATA & tucr_pkg::MASK_SYNC_PERIOD;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      cycle_count_threshold_reg <= tucr_pkg::RESET_VALUE;
    end else if (wr_en && sel == TUCR_SEL_CC) begin
      cycle_count_threshold_reg <= PWDATA & tucr_pkg::MASK_CC_THRESHOLD;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      branch_broadcast_scope_reg <= tucr_pkg::RESET_VALUE;
    end else if (wr_en && sel == TUCR_SEL_BB) begin
      branch_broadcast_scope_reg <= PWDATA & tucr_pkg::MASK_BB_SCOPE;
    end
  end

  // Read data
  always_comb begin
    PRDATA = '0;

    if (PSEL && !PWRITE) begin
      unique case (sel)
        TUCR_SEL_STALL: PRDATA = trace_stall_control_reg;
        TUCR_SEL_TS:    PRDATA = timestamp_event_control_reg;
        TUCR_SEL_SYNC:  PRDATA = sync_period_reg;
        TUCR_SEL_CC:    PRDATA = cycle_count_threshold_reg;
        TUCR_SEL_BB:    PRDATA = branch_broadcast_scope_reg;
        TUCR_SEL_STAT:  PRDATA = status_word;
        TUCR_SEL_NONE:  PRDATA = '0;
      endcase
    end
  end

  // Stall, drop and favour policy
  logic [1:0] level;
  logic [1:0] drop_sel;
  logic       instr_low;
  logic       data_low;
  logic       stall_next;
  logic       drop_ld_next;
  logic       drop_st_next;
  logic       fav_next;

  assign level    = trace_stall_control_reg[tucr_pkg::LEVEL_HI:
                                            tucr_pkg::LEVEL_LO];

  assign drop_sel = trace_stall_control_reg[tucr_pkg::DROP_SEL_HI:
                                            tucr_pkg::DROP_SEL_LO];

  // Level zero compares against zero space and is never true
  assign instr_low = INSTR_SPACE < level_space(level);
  assign data_low  = DATA_SPACE < level_space(level);

  always_comb begin
    stall_next = (trace_stall_control_reg[tucr_pkg::DATA_HOLD_BIT]
                  && data_low)
              || (trace_stall_control_reg[tucr_pkg::INSTR_HOLD_BIT]
                  && instr_low);

    drop_ld_next = data_low && ((drop_sel == tucr_pkg::DROP_LOAD) ||
                                (drop_sel == tucr_pkg::DROP_BOTH));

    drop_st_next = data_low && ((drop_sel == tucr_pkg::DROP_STORE) ||
                                (drop_sel == tucr_pkg::DROP_BOTH));

    fav_next = trace_stall_control_reg[tucr_pkg::INSTR_FAV_BIT]
               && instr_low;
  end

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      CORE_STALL <= 1'b0;
    end else begin
      CORE_STALL <= stall_next;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      DROP_LOADS  <= 1'b0;
      DROP_STORES <= 1'b0;
    end else begin
      DROP_LOADS  <= drop_ld_next;
      DROP_STORES <= drop_st_next;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      INSTR_FAVOUR <= 1'b0;
    end else begin
      INSTR_FAVOUR <= fav_next;
    end
  end

  // Timestamp insertion
  logic ts_hit;

  tucr_resource_select u_ts_select (
    .kind       (timestamp_event_control_reg[tucr_pkg::TS_KIND_BIT]),
    .index      (timestamp_event_control_reg[tucr_pkg::TS_SEL_HI:0]),
    .single_res (RESOURCE),
    .pair_res   (RESOURCE_PAIR),
    .hit        (ts_hit)
  );

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      TS_INSTR <= 1'b0;
      TS_DATA  <= 1'b0;
    end else begin
      TS_INSTR <= ts_hit;
      TS_DATA  <= ts_hit && DATA_TRACE_ON;
    end
  end

  // Periodic synchronization
  tucr_sync_counter u_sync (
    .clk         (REF_CLK),
    .rst_n       (RSTN),
    .period      (sync_period_reg[tucr_pkg::PERIOD_HI:0]),
    .instr_bytes (INSTR_BYTES),
    .data_bytes  (DATA_BYTES),
    .sync_req    (SYNC_REQUEST)
  );

  // Cycle count threshold
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      CC_THRESHOLD <= '0;
      CC_ACTIVE    <= 1'b0;
    end else begin
      CC_THRESHOLD <= cycle_count_threshold_reg[tucr_pkg::CC_HI:0];
      CC_ACTIVE    <= CYCLE_COUNT_ENABLE;
    end
  end

  // Branch broadcast scope
  logic [tucr_pkg::NUM_RANGES-1:0] chosen;
  logic                            in_chosen;
  logic                            bb_next;

  genvar g;

  generate
    for (g = 0; g < tucr_pkg::NUM_RANGES; g++) begin : g_range
      assign chosen[g] = branch_broadcast_scope_reg[g] && RANGE_HIT[g];
    end
  endgenerate

  assign in_chosen = |chosen;

  always_comb begin
    if (!BRANCH_BROADCAST_ENABLE) begin
      bb_next = 1'b0;
    end else if (branch_broadcast_scope_reg[tucr_pkg::BB_MODE_BIT]) begin
      bb_next = in_chosen;
    end else begin
      bb_next = !in_chosen;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      BB_ACTIVE <= 1'b0;
    end else begin
      BB_ACTIVE <= bb_next;
    end
  end

  // Live status of the policy outputs, branch broadcast and both space comparisons
  always_comb begin
    status_word = '0;

    status_word[tucr_pkg::ST_CORE_STALL] = CORE_STALL;
    status_word[tucr_pkg::ST_DROP_LOAD]  = DROP_LOADS;
    status_word[tucr_pkg::ST_DROP_STORE] = DROP_STORES;
    status_word[tucr_pkg::ST_INSTR_FAV]  = INSTR_FAVOUR;
    status_word[tucr_pkg::ST_BB_ACTIVE]  = BB_ACTIVE;
    status_word[tucr_pkg::ST_DATA_LOW]   = data_low;
    status_word[tucr_pkg::ST_INSTR_LOW]  = instr_low;
  end

endmodule // tucr_top

/* bench/tucr_core_model.sv */
/*
  Behavioural model of the traced core: emits trace bytes each cycle
  while running and emits none while the control bank holds it.
  Assumes the clock and synchronous active-low reset of the bank.
*/
module tucr_core_model (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  // Control
  input  wire logic                         stall,
  input  wire logic                         run,
  // Trace bytes produced
  output logic [tucr_pkg::BYTES_W-1:0]      instr_bytes,
  output logic [tucr_pkg::BYTES_W-1:0]      data_bytes
);
  timeunit 1ns;
  timeprecision 1ns;

  // A held core retires nothing, so it traces nothing
  always_ff @(posedge clk) begin
    if (!rst_n || !run || stall) begin
      instr_bytes <= 4'h0;
      data_bytes  <= 4'h0;
    end else begin
      instr_bytes <= 4'hF;
      data_bytes  <= 4'hF;
    end
  end
endmodule // tucr_core_model

/* bench/tucr_top_properties.sv */
/*
  Checker for the control bank outputs against shadow copies of the
  registers, rebuilt from APB writes.
  Assumes zero-wait APB and outputs one cycle behind their causes.
*/
module tucr_checker (
  // Clock and reset
  input wire logic                         REF_CLK,
  input wire logic                         RSTN,
  // APB
  input wire logic                         PSEL,
  input wire logic                         PENABLE,
  input wire logic                         PWRITE,
  input wire logic [11:0]                  PADDR,
  input wire logic [31:0]                  PWDATA,
  // Stall and drop policy
  input wire logic [tucr_pkg::SPACE_W-1:0] INSTR_SPACE,
  input wire logic [tucr_pkg::SPACE_W-1:0] DATA_SPACE,
  input wire logic                         CORE_STALL,
  input wire logic                         DROP_LOADS,
  input wire logic                         DROP_STORES,
  input wire logic                         INSTR_FAVOUR,
  // Timestamp and sync
  input wire logic [15:0]                  RESOURCE,
  input wire logic [7:0]                   RESOURCE_PAIR,
  input wire logic                         TS_INSTR,
  input wire logic                         TS_DATA,
  input wire logic                         SYNC_REQUEST,
  // Cycle count and branch scope
  input wire logic                         CYCLE_COUNT_ENABLE,
  input wire logic [11:0]                  CC_THRESHOLD,
  input wire logic                         CC_ACTIVE,
  input wire logic                         BRANCH_BROADCAST_ENABLE,
  input wire logic [3:0]                   RANGE_HIT,
  input wire logic                         BB_ACTIVE
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);

  logic [12:0] st_reg;
  logic [7:0]  ts_reg;
  logic [4:0]  pe_reg;
  logic [11:0] cc_reg;
  logic [8:0]  bb_reg;
  logic [7:0]  thr;
  logic        wr, d_low, i_low, ts_hit, any_hit, bb_hit;

  assign wr      = PSEL && PENABLE && PWRITE;
  assign d_low   = DATA_SPACE < thr;
  assign i_low   = INSTR_SPACE < thr;
  assign ts_hit  = ts_reg[7] ? RESOURCE_PAIR[ts_reg[2:0]]
                             : RESOURCE[ts_reg[3:0]];
  assign any_hit = |(RANGE_HIT & bb_reg[3:0]);
  assign bb_hit  = BRANCH_BROADCAST_ENABLE && (bb_reg[8] == any_hit);

  always_comb
    case (st_reg[3:2])
      2'h0: thr = tucr_pkg::SPACE_LEVEL0;
      2'h1: thr = tucr_pkg::SPACE_LEVEL1;
      2'h2: thr = tucr_pkg::SPACE_LEVEL2;
      default: thr = tucr_pkg::SPACE_LEVEL3;
    endcase

  // Shadow registers follow completed writes
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      st_reg <= 13'h0;
      ts_reg <= 8'h0;
      pe_reg <= 5'h0;
      cc_reg <= 12'h0;
      bb_reg <= 9'h0;
    end else if (wr) begin
      case (PADDR)
        tucr_pkg::OFS_STALL_CTRL:   st_reg <= PWDATA[12:0];
        tucr_pkg::OFS_TS_CTRL:      ts_reg <= PWDATA[7:0];
        tucr_pkg::OFS_SYNC_PERIOD:  pe_reg <= PWDATA[4:0];
        tucr_pkg::OFS_CC_THRESHOLD: cc_reg <= PWDATA[11:0];
        tucr_pkg::OFS_BB_SCOPE:     bb_reg <= PWDATA[8:0];
        default: ;
      endcase
    end
  end

  stall_follow_a : assert property (
    CORE_STALL == $past((st_reg[9] && d_low) || (st_reg[8] && i_low)))
    else $error("core stall disagrees with holds and space");
  load_drop_a : assert property (
    DROP_LOADS == $past(st_reg[11] && d_low))
    else $error("load drop disagrees with select and space");
  store_drop_a : assert property (
    DROP_STORES == $past(st_reg[12] && d_low))
    else $error("store drop disagrees with select and space");
  favour_follow_a : assert property (
    INSTR_FAVOUR == $past(st_reg[10] && i_low))
    else $error("favour disagrees with bit and space");
  level_zero_a : assert property (
    (st_reg[3:2] == 2'h0) [*2] |-> !CORE_STALL)
    else $error("core stalled at the lowest level");
  ts_select_a : assert property (
    TS_INSTR == $past(ts_hit))
    else $error("timestamp not from selected resource");
  ts_data_gate_a : assert property (
    TS_DATA |-> TS_INSTR)
    else $error("data timestamp without instruction timestamp");
  sync_quiet_a : assert property (
    (pe_reg == 5'h0) [*2] |-> !SYNC_REQUEST)
    else $error("sync request with period zero");
  sync_pulse_a : assert property (
    SYNC_REQUEST && (pe_reg >= 5'h06) |=> !SYNC_REQUEST)
    else $error("sync request longer than one cycle");
  cc_copy_a : assert property (
    CC_THRESHOLD == $past(cc_reg))
    else $error("threshold not the written value");
  cc_enable_a : assert property (
    CC_ACTIVE == $past(CYCLE_COUNT_ENABLE))
    else $error("cycle count active does not follow enable");
  bb_scope_a : assert property (
    BB_ACTIVE == $past(bb_hit))
    else $error("branch broadcast disagrees with scope");
endmodule // tucr_checker

bind tucr_top tucr_checker u_checker (
  .REF_CLK, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
  .INSTR_SPACE, .DATA_SPACE, .CORE_STALL, .DROP_LOADS, .DROP_STORES,
  .INSTR_FAVOUR, .RESOURCE, .RESOURCE_PAIR, .TS_INSTR, .TS_DATA,
  .SYNC_REQUEST, .CYCLE_COUNT_ENABLE, .CC_THRESHOLD, .CC_ACTIVE,
  .BRANCH_BROADCAST_ENABLE, .RANGE_HIT, .BB_ACTIVE
);

/* bench/test_trace_unit_control_regs.sv */
/*
  Testbench for the trace unit control bank: APB register access,
  stall and drop policy, timestamp choice, sync period, branch scope.
  Assumes zero-wait APB and a core model fed by the stall output.
*/
module test_trace_unit_control_regs;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk = 1'b0, rstn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr, cct;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  ispace, dspace, pair;
  logic [15:0] res;
  logic [3:0]  rhit, ib, db;
  logic        dton, cce, bbe, run, low;
  logic        stall, dl, ds, fav, tsi, tsd, sreq, cca, bba;
  int          fails, checks, cyc, pulses, total;
  logic [11:0] ofs_tab [5] = '{tucr_pkg::OFS_STALL_CTRL,
    tucr_pkg::OFS_TS_CTRL, tucr_pkg::OFS_SYNC_PERIOD,
    tucr_pkg::OFS_CC_THRESHOLD, tucr_pkg::OFS_BB_SCOPE};
  logic [31:0] msk_tab [5] = '{tucr_pkg::MASK_STALL_CTRL,
    tucr_pkg::MASK_TS_CTRL, tucr_pkg::MASK_SYNC_PERIOD,
    tucr_pkg::MASK_CC_THRESHOLD, tucr_pkg::MASK_BB_SCOPE};
  logic [7:0]  thr_tab [4] = '{tucr_pkg::SPACE_LEVEL0,
    tucr_pkg::SPACE_LEVEL1, tucr_pkg::SPACE_LEVEL2, tucr_pkg::SPACE_LEVEL3};
  // Enable, mode, mask, hit, expected broadcast
  logic [10:0] bb_tab [7] = '{11'h41F, 11'h462, 11'h469, 11'h6A9,
    11'h6A4, 11'h711, 11'h2A8};

  tucr_top DUT (.REF_CLK(clk), .RSTN(rstn), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .INSTR_SPACE(ispace), .DATA_SPACE(dspace), .CORE_STALL(stall),
    .DROP_LOADS(dl), .DROP_STORES(ds), .INSTR_FAVOUR(fav),
    .RESOURCE(res), .RESOURCE_PAIR(pair), .DATA_TRACE_ON(dton),
    .TS_INSTR(tsi), .TS_DATA(tsd), .INSTR_BYTES(ib), .DATA_BYTES(db),
    .SYNC_REQUEST(sreq), .CYCLE_COUNT_ENABLE(cce), .CC_THRESHOLD(cct),
    .CC_ACTIVE(cca), .BRANCH_BROADCAST_ENABLE(bbe), .RANGE_HIT(rhit),
    .BB_ACTIVE(bba));
  tucr_core_model u_core (.clk(clk), .rst_n(rstn), .stall(stall),
    .run(run), .instr_bytes(ib), .data_bytes(db));

  always #50 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (sreq === 1'b1) pulses++;
    total += int'(ib) + int'(db);
    if (cyc == 5000) begin
      fails++;
      print_verdict();
    end
  end

  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // Free space in, then stall, drop loads, drop stores, favour out
  task automatic pol(input logic [7:0] i, input logic [7:0] d,
                     input logic [3:0] e);
    @(posedge clk);
    ispace <= i;
    dspace <= d;
    settle();
    chk(32'({stall, dl, ds, fav}), 32'(e));
  endtask

  // Bytes of both streams counted against the sync pulses seen
  task automatic burst(input int sh);
    @(posedge clk);
    pulses = 0;
    total  = 0;
    run <= 1'b1;
    repeat (100) @(posedge clk);
    run <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk(32'(pulses), (sh == 0) ? 32'h0 : 32'(total >> sh));
  endtask

  initial begin
    {rstn, psel, penable, pwrite, run, dton, cce, bbe} = '0;
    {paddr, pwdata, ispace, dspace, pair, res, rhit} = '0;
    {fails, checks, cyc, pulses, total} = '0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    foreach (ofs_tab[k]) begin
      apb(1'b1, ofs_tab[k], 32'hFFFFFFFF);
      apb(1'b0, ofs_tab[k], 32'h0);
      chk(rd, msk_tab[k]);
      chk(32'(err), 32'h0);
      apb(1'b1, ofs_tab[k], 32'h0);
    end
    apb(1'b0, 12'h048, 32'h0);
    chk(rd, 32'h0);
    chk(32'(err), 32'h1);
    for (int lv = 0; lv < 4; lv++) begin
      low = (lv != 0);
      for (int sl = 0; sl < 4; sl++) begin
        apb(1'b1, tucr_pkg::OFS_STALL_CTRL,
            32'({sl[1:0], 3'h6, 4'h0, lv[1:0], 2'h0}));
        pol(thr_tab[lv] - 8'h01, thr_tab[lv] - 8'h01,
            {low, low & sl[0], low & sl[1], low});
        pol(thr_tab[lv], thr_tab[lv], 4'h0);
      end
      apb(1'b1, tucr_pkg::OFS_STALL_CTRL, 32'({4'h1, 4'h0, lv[1:0], 2'h0}));
      pol(thr_tab[lv], thr_tab[lv] - 8'h01, 4'h0);
      pol(thr_tab[lv] - 8'h01, thr_tab[lv], {low, 3'h0});
    end
    apb(1'b0, tucr_pkg::OFS_STATUS, 32'h0);
    chk(rd, 32'h41);
    apb(1'b1, tucr_pkg::OFS_STALL_CTRL, 32'h0);
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, tucr_pkg::OFS_TS_CTRL, 32'(i));
      @(posedge clk);
      res  <= 16'h0001 << i;
      dton <= i[0];
      settle();
      chk(32'({tsi, tsd}), 32'({1'b1, i[0]}));
    end
    for (int j = 0; j < 8; j++) begin
      apb(1'b1, tucr_pkg::OFS_TS_CTRL, 32'({4'h8, 1'b1, j[2:0]}));
      @(posedge clk);
      res  <= 16'hFFFF;
      pair <= 8'h01 << j;
      settle();
      chk(32'({tsi, tsd}), 32'h3);
      @(posedge clk);
      pair <= ~(8'h01 << j);
      settle();
      chk(32'({tsi, tsd}), 32'h0);
    end
    apb(1'b1, tucr_pkg::OFS_SYNC_PERIOD, 32'h0);
    apb(1'b1, tucr_pkg::OFS_SYNC_PERIOD, 32'h8);
    burst(8);
    apb(1'b1, tucr_pkg::OFS_SYNC_PERIOD, 32'h0);
    burst(0);
    apb(1'b1, tucr_pkg::OFS_CC_THRESHOLD, 32'h00000ABC);
    @(posedge clk);
    cce <= 1'b1;
    settle();
    chk(32'({cca, cct}), 32'h1ABC);
    @(posedge clk);
    cce <= 1'b0;
    settle();
    chk(32'({cca, cct}), 32'h0ABC);
    foreach (bb_tab[k]) begin
      apb(1'b1, tucr_pkg::OFS_BB_SCOPE,
          32'({bb_tab[k][9], 4'h0, bb_tab[k][8:5]}));
      @(posedge clk);
      bbe  <= bb_tab[k][10];
      rhit <= bb_tab[k][4:1];
      settle();
      chk(32'(bba), 32'(bb_tab[k][0]));
    end
    print_verdict();
  end
endmodule // test_trace_unit_control_regs
